// ### verilog/usb_port_pkg.sv
// Purpose: Shared constants for the USB port control and address block.
// Assumes: 50 MHz device clock, byte-wide register port.
// Notes: Offsets are the printed byte addresses of the register port.
package usb_port_pkg;
	localparam logic [7:0] ADDR_DEVICE_ADDRESS = 8'h10;
	localparam logic [7:0] ADDR_PORT_STATUS_CONTROL = 8'h1f;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Status and control field positions.
	localparam int BIT_PULLUP_EN = 7;
	localparam int BIT_REG_EN = 6;
	localparam int BIT_IRQ_SEL = 5;
	localparam int BIT_RESERVED = 4;
	localparam int BIT_ACTIVITY = 3;
	localparam int FORCE_HI = 2;
	localparam int FORCE_LO = 0;
	// Device address field positions.
	localparam int BIT_ADDR_EN = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;
	localparam int ADDR_WIDTH = 7;
	// Line forcing codes.
	localparam logic [2:0] FORCE_NONE = 3'h0;
	localparam logic [2:0] FORCE_K = 3'h1;
	localparam logic [2:0] FORCE_J = 3'h2;
	localparam logic [2:0] FORCE_SE0 = 3'h3;
	// Low-duration window, in microseconds, and clock rate.
	localparam int CLOCK_HZ = 50000000;
	localparam int LOW_MIN_US = 128;
	localparam int LOW_MAX_US = 256;
	// Least time converts to whole cycles with no rounding up.
	localparam int LOW_MIN_CYCLES =
		(LOW_MIN_US * (CLOCK_HZ / 1000000) + 0);
	localparam int NUM_ENDPOINTS = 3;
endpackage : usb_port_pkg

// ### verilog/low_timer.sv
// Purpose: Times how long a watched condition has held without a break.
// Assumes: Condition is already synchronised to the clock.
// Notes: Fires a single pulse when the run reaches the limit.
`timescale 1ns/1ps
module low_timer
#(
	parameter int LIMIT = 6400
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cond,
	output logic fire
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] TOP = W'(LIMIT);
	logic [W-1:0] count;

	// The count saturates so one long run gives one pulse only.
	always_ff @(posedge clock)
	begin
		if (!rst_n || !cond)
			count <= '0;
		else if (count != TOP)
			count <= count + W'(1);
	end

	assign fire = cond && (count == TOP - W'(1));
endmodule : low_timer

// ### verilog/usb_port_control.sv
// Purpose: Port status, control and device address of a USB/PS2 port.
// Assumes: Registers reached over a strobed byte port, read data next cycle.
// Notes: The packet engine itself lives outside; this block gates it.
`timescale 1ns/1ps
module usb_port_control
	import usb_port_pkg::*;
#(
	parameter int LOW_CYCLES = LOW_MIN_CYCLES
)
(
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RST_N,
	// Register port.
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// D+ and D- pins, each as input, output and enable.
	input wire logic DP_IN,
	input wire logic DM_IN,
	output logic DP_OUT,
	output logic DM_OUT,
	output logic DP_OE,
	output logic DM_OE,
	output logic OPEN_DRAIN,
	output logic PULLUP_EN,
	output logic REGULATOR_EN,
	// Serial engine side.
	input wire logic ENGINE_DP_OUT,
	input wire logic ENGINE_DM_OUT,
	input wire logic ENGINE_OE,
	input wire logic ENGINE_ACTIVITY,
	input wire logic TOKEN_VALID,
	input wire logic [6:0] TOKEN_ADDR,
	input wire logic [3:0] TOKEN_ENDP,
	output logic TOKEN_ACCEPT,
	// Event pulses towards the interrupt controller.
	output logic BUS_RESET_IRQ,
	output logic PS2_ACTIVITY_IRQ
);
	logic pullup_en;
	logic reg_en;
	logic irq_sel;
	logic activity;
	logic [2:0] force_code;
	logic addr_en;
	logic [ADDR_WIDTH-1:0] dev_addr;
	logic dp_meta, dp_sync, dm_meta, dm_sync;
	logic se0_fire, ps2_fire;
	logic wr_ctl, wr_addr;
	logic [7:0] ctl_view, addr_view;

	// All checks below run on the one device clock.
	default clocking cb_main @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	assign wr_ctl = WR && (ADDR == ADDR_PORT_STATUS_CONTROL);
	assign wr_addr = WR && (ADDR == ADDR_DEVICE_ADDRESS);

	// Pins come from outside the clock domain.
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			dp_meta <= 1'b1;
			dm_meta <= 1'b1;
			dp_sync <= 1'b1;
			dm_sync <= 1'b1;
		end
		else
		begin
			dp_meta <= DP_IN;
			dm_meta <= DM_IN;
			dp_sync <= dp_meta;
			dm_sync <= dm_meta;
		end
	end

	low_timer #(.LIMIT(LOW_CYCLES)) se0_timer
	(
		.clock(CLOCK),
		.rst_n(RST_N),
		.cond(!dp_sync && !dm_sync),
		.fire(se0_fire)
	);

	low_timer #(.LIMIT(LOW_CYCLES)) ps2_timer
	(
		.clock(CLOCK),
		.rst_n(RST_N),
		.cond(!dm_sync),
		.fire(ps2_fire)
	);

	assign PS2_ACTIVITY_IRQ = irq_sel && ps2_fire;
	assign BUS_RESET_IRQ = !irq_sel && se0_fire;

	// Control fields; the reserved bit is never stored.
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			pullup_en <= 1'b0;
			reg_en <= 1'b0;
			irq_sel <= 1'b0;
			force_code <= FORCE_NONE;
		end
		else if (wr_ctl)
		begin
			pullup_en <= WDATA[BIT_PULLUP_EN];
			reg_en <= WDATA[BIT_REG_EN];
			irq_sel <= WDATA[BIT_IRQ_SEL];
			force_code <= WDATA[FORCE_HI:FORCE_LO];
		end
	end

	// write zero clears, set wins over the clear.
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			activity <= 1'b0;
		else if (ENGINE_ACTIVITY)
			activity <= 1'b1;
		else if (wr_ctl && !WDATA[BIT_ACTIVITY])
			activity <= 1'b0;
	end

	// bus reset clears it, in USB mode only (irq_sel low).
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N || BUS_RESET_IRQ)
		begin
			addr_en <= 1'b0;
			dev_addr <= '0;
		end
		else if (wr_addr)
		begin
			addr_en <= WDATA[BIT_ADDR_EN];
			dev_addr <= WDATA[ADDR_HI:ADDR_LO];
		end
	end

	assign TOKEN_ACCEPT = TOKEN_VALID && addr_en &&
		(TOKEN_ADDR == dev_addr) && (TOKEN_ENDP < 4'(NUM_ENDPOINTS));

	assign PULLUP_EN = pullup_en;
	assign REGULATOR_EN = reg_en;
	assign OPEN_DRAIN = force_code[FORCE_HI];

	always_comb
	begin
		DP_OUT = 1'b0;
		DM_OUT = 1'b0;
		DP_OE = 1'b0;
		DM_OE = 1'b0;
		case (force_code)
			FORCE_NONE:
			begin
				DP_OUT = ENGINE_DP_OUT;
				DM_OUT = ENGINE_DM_OUT;
				DP_OE = ENGINE_OE;
				DM_OE = ENGINE_OE;
			end
			FORCE_K:
			begin
				DP_OUT = 1'b1;
				DP_OE = 1'b1;
				DM_OE = 1'b1;
			end
			FORCE_J:
			begin
				DM_OUT = 1'b1;
				DP_OE = 1'b1;
				DM_OE = 1'b1;
			end
			FORCE_SE0:
			begin
				DP_OE = 1'b1;
				DM_OE = 1'b1;
			end
			default:
			begin
				// Bit 0 set releases D+, bit 1 set releases D-.
				DP_OE = !force_code[0];
				DM_OE = !force_code[1];
			end
		endcase
	end

	always_comb
	begin
		ctl_view = RESET_VALUE;
		ctl_view[BIT_PULLUP_EN] = pullup_en;
		ctl_view[BIT_REG_EN] = reg_en;
		ctl_view[BIT_IRQ_SEL] = irq_sel;
		ctl_view[BIT_ACTIVITY] = activity;
		ctl_view[FORCE_HI:FORCE_LO] = force_code;
		addr_view = {addr_en, dev_addr};
	end

	// Unmapped reads return zero.
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			RDATA <= RESET_VALUE;
		else if (RD && ADDR == ADDR_PORT_STATUS_CONTROL)
			RDATA <= ctl_view;
		else if (RD && ADDR == ADDR_DEVICE_ADDRESS)
			RDATA <= addr_view;
		else
			RDATA <= RESET_VALUE;
	end

	// activity survives a write of one
	a_activity_keep: assert property (
		activity && !(wr_ctl && !WDATA[BIT_ACTIVITY]) |=> activity)
		else $error("activity flag lost");
	a_activity_clear: assert property (
		wr_ctl && !WDATA[BIT_ACTIVITY] && !ENGINE_ACTIVITY |=> !activity)
		else $error("activity flag not cleared");
	a_activity_set: assert property (
		ENGINE_ACTIVITY |=> activity)
		else $error("activity flag not set");
	a_pullup_write: assert property (
		wr_ctl |=> PULLUP_EN == $past(WDATA[BIT_PULLUP_EN]))
		else $error("pull-up enable wrong");
	a_reg_write: assert property (
		wr_ctl |=> REGULATOR_EN == $past(WDATA[BIT_REG_EN]))
		else $error("regulator enable wrong");
	a_addr_write: assert property (
		wr_addr && !BUS_RESET_IRQ |=> {addr_en, dev_addr} == $past(WDATA))
		else $error("address write lost");
	a_addr_clear: assert property (
		BUS_RESET_IRQ |=> !addr_en && dev_addr == '0)
		else $error("address not cleared");
	sequence s_read_addr;
		RD && ADDR == ADDR_DEVICE_ADDRESS;
	endsequence
	a_read_addr: assert property (
		s_read_addr |=> RDATA == $past(addr_view))
		else $error("address read wrong");
	a_token_gate: assert property (
		TOKEN_ACCEPT |-> addr_en && TOKEN_ADDR == dev_addr)
		else $error("token accepted while disabled");
	a_token_endp: assert property (
		TOKEN_ACCEPT |-> TOKEN_ENDP < 4'(NUM_ENDPOINTS))
		else $error("token for missing endpoint");
	a_reset_time: assert property (
		BUS_RESET_IRQ |-> !irq_sel && !dp_sync && !dm_sync)
		else $error("bus reset without SE0");
	a_reset_pulse: assert property (
		BUS_RESET_IRQ |=> !BUS_RESET_IRQ)
		else $error("bus reset pulse too long");
	a_force_none: assert property (
		force_code == FORCE_NONE |-> DP_OE == ENGINE_OE &&
		DM_OE == ENGINE_OE && DP_OUT == ENGINE_DP_OUT &&
		DM_OUT == ENGINE_DM_OUT)
		else $error("engine drive not passed");
	a_force_k: assert property (
		force_code == FORCE_K |-> DP_OE && DM_OE && DP_OUT && !DM_OUT)
		else $error("K state wrong");
	a_drain_low: assert property (
		force_code[FORCE_HI] |-> !DP_OUT && !DM_OUT)
		else $error("open drain drove high");
	a_release_map: assert property (
		force_code[FORCE_HI] |-> DP_OE == !force_code[0] &&
		DM_OE == !force_code[1])
		else $error("open drain release wrong");
	// PS/2 event only in PS/2 mode
	a_ps2_mode: assert property (
		PS2_ACTIVITY_IRQ |-> irq_sel && !dm_sync && !BUS_RESET_IRQ)
		else $error("PS2 event in USB mode");
endmodule : usb_port_control

// ### bench/line_host.sv
// Purpose: Far-side host that resolves the D+ and D- wires.
// Assumes: The host holds pull-ups, so a released line reads high.
// Notes: The host drives only while the bench asks it to.
`timescale 1ns/1ps
module line_host
(
	// Device drive.
	input wire logic dp_out,
	input wire logic dm_out,
	input wire logic dp_oe,
	input wire logic dm_oe,
	// Host drive.
	input wire logic drive,
	input wire logic dp,
	input wire logic dm,
	// Resolved levels.
	output logic dp_in,
	output logic dm_in
);
	assign dp_in = dp_oe ? dp_out : (drive ? dp : 1'b1);
	assign dm_in = dm_oe ? dm_out : (drive ? dm : 1'b1);
endmodule : line_host

// ### bench/usb_port_control_test.sv
// Purpose: Self-checking bench for the USB port control block.
// Assumes: Low-time limit shortened to 8 cycles.
// Notes: The bench plays the serial engine and the processor.
`timescale 1ns/1ps
module usb_port_control_test import usb_port_pkg::*;;
	localparam int LIM = 8;
	logic clock = 0, rst_n = 0, wr = 0, rd = 0, drive = 0, h_dp = 1;
	logic h_dm = 1, e_dp = 0, e_dm = 0, e_oe = 0, e_act = 0, t_val = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic [6:0] t_addr = 7'h00;
	logic [3:0] t_endp = 4'h0;
	logic dp_in, dm_in, dp_out, dm_out, dp_oe, dm_oe, od, pu, re;
	logic t_acc, bus_irq, ps2_irq;
	logic [7:0] fx [8] = '{8'h0d, 8'h0e, 8'h0d, 8'h0c,
		8'h1c, 8'h14, 8'h18, 8'h10};
	int fail_count = 0, num_checks = 0, at;
	usb_port_control #(.LOW_CYCLES(LIM)) i_dut (.CLOCK(clock),
		.RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .DP_IN(dp_in), .DM_IN(dm_in), .DP_OUT(dp_out),
		.DM_OUT(dm_out), .DP_OE(dp_oe), .DM_OE(dm_oe), .OPEN_DRAIN(od),
		.PULLUP_EN(pu), .REGULATOR_EN(re), .ENGINE_DP_OUT(e_dp),
		.ENGINE_DM_OUT(e_dm), .ENGINE_OE(e_oe), .ENGINE_ACTIVITY(e_act),
		.TOKEN_VALID(t_val), .TOKEN_ADDR(t_addr), .TOKEN_ENDP(t_endp),
		.TOKEN_ACCEPT(t_acc), .BUS_RESET_IRQ(bus_irq),
		.PS2_ACTIVITY_IRQ(ps2_irq));
	line_host host (.dp_out(dp_out), .dm_out(dm_out), .dp_oe(dp_oe),
		.dm_oe(dm_oe), .drive(drive), .dp(h_dp), .dm(h_dm),
		.dp_in(dp_in), .dm_in(dm_in));
	always #10 clock = ~clock;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1;
	endtask : wreg
	task rreg(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task tok(input logic [6:0] a, input logic [3:0] e, input logic x);
		@(posedge clock);
		t_val <= 1'b1;
		t_addr <= a;
		t_endp <= e;
		@(negedge clock);
		chk({7'h00, t_acc}, {7'h00, x});
	endtask : tok
	// Holds a low run of n cycles and watches four cycles past it, so a
	// pulse that the synchroniser delays is still seen; at is the cycle the
	// wanted pulse came, -1 if the other pulse fired.
	task low(input logic s, input int n);
		at = 0;
		@(posedge clock);
		drive <= 1'b1;
		h_dp <= s;
		h_dm <= 1'b0;
		for (int k = 1; k <= n + 4; k++)
		begin
			@(posedge clock);
			if (k == n)
				drive <= 1'b0;
			#1;
			if ((s ? ps2_irq : bus_irq) === 1'b1 && at == 0)
				at = k;
			if ((s ? bus_irq : ps2_irq) === 1'b1)
				at = -1;
		end
	endtask : low
	task t_reset;
		rreg(ADDR_DEVICE_ADDRESS);
		chk(d, 8'h00);
		rreg(ADDR_PORT_STATUS_CONTROL);
		chk(d, 8'h00);
		rreg(8'h20);
		chk(d, 8'h00);
	endtask : t_reset
	task t_ctl;
		wreg(ADDR_PORT_STATUS_CONTROL, 8'hc0);
		chk({6'h00, pu, re}, 8'h03);
		wreg(ADDR_PORT_STATUS_CONTROL, 8'h00);
		chk({6'h00, pu, re}, 8'h00);
	endtask : t_ctl
	task t_force;
		@(posedge clock);
		e_dp <= 1'b0;
		e_dm <= 1'b1;
		e_oe <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			wreg(ADDR_PORT_STATUS_CONTROL, 8'(i));
			chk({3'h0, od, dp_oe, dm_oe, dp_out, dm_out}, fx[i]);
		end
		@(posedge clock);
		e_oe <= 1'b0;
		wreg(ADDR_PORT_STATUS_CONTROL, 8'h00);
		chk({6'h00, dp_oe, dm_oe}, 8'h00);
	endtask : t_force
	task t_act;
		@(posedge clock);
		e_act <= 1'b1;
		@(posedge clock);
		e_act <= 1'b0;
		rreg(ADDR_PORT_STATUS_CONTROL);
		chk(d, 8'h08);
		wreg(ADDR_PORT_STATUS_CONTROL, 8'h08);
		rreg(ADDR_PORT_STATUS_CONTROL);
		chk(d, 8'h08);
		wreg(ADDR_PORT_STATUS_CONTROL, 8'h00);
		rreg(ADDR_PORT_STATUS_CONTROL);
		chk(d, 8'h00);
		// Engine activity in the very cycle of a clearing write must win.
		@(posedge clock);
		e_act <= 1'b1;
		wreg(ADDR_PORT_STATUS_CONTROL, 8'h00);
		@(posedge clock);
		e_act <= 1'b0;
		rreg(ADDR_PORT_STATUS_CONTROL);
		chk(d, 8'h08);
	endtask : t_act
	task t_tok;
		wreg(ADDR_DEVICE_ADDRESS, 8'haa);
		rreg(ADDR_DEVICE_ADDRESS);
		chk(d, 8'haa);
		for (int e = 0; e < 4; e++)
			tok(7'h2a, 4'(e), e < NUM_ENDPOINTS);
		tok(7'h2b, 4'h0, 1'b0);
		wreg(ADDR_DEVICE_ADDRESS, 8'h2a);
		tok(7'h2a, 4'h0, 1'b0);
		@(posedge clock);
		t_val <= 1'b0;
	endtask : t_tok
	task t_irq;
		wreg(ADDR_DEVICE_ADDRESS, 8'haa);
		low(1'b0, LIM - 1);
		chk(8'(at), 8'h00);
		rreg(ADDR_DEVICE_ADDRESS);
		chk(d, 8'haa);
		low(1'b0, LIM + 4);
		chk({7'h00, at >= LIM && at <= LIM + 3}, 8'h01);
		rreg(ADDR_DEVICE_ADDRESS);
		chk(d, 8'h00);
		wreg(ADDR_PORT_STATUS_CONTROL, 8'h27);
		low(1'b1, LIM + 4);
		chk({7'h00, at >= LIM && at <= LIM + 3}, 8'h01);
	endtask : t_irq
	// A second hardware reset in mid-run must clear both registers.
	task t_hw;
		wreg(ADDR_DEVICE_ADDRESS, 8'haa);
		wreg(ADDR_PORT_STATUS_CONTROL, 8'hc7);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rreg(ADDR_DEVICE_ADDRESS);
		chk(d, 8'h00);
		rreg(ADDR_PORT_STATUS_CONTROL);
		chk(d, 8'h00);
		chk({6'h00, pu, re}, 8'h00);
	endtask : t_hw
	task end_of_test;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (2000) @(posedge clock);
		fail_count++;
		end_of_test();
	end
	initial
	begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_ctl();
		t_force();
		t_act();
		t_tok();
		t_irq();
		t_hw();
		end_of_test();
	end
endmodule : usb_port_control_test
